// *** bench/sspr_regs_top_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "sspr_regs.vh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
	$display("ERROR %s exp %h got %h", nm, e, g); end end
module sspr_regs_top_bench;
	logic clk, rst_n, psel, pen, pwr, scl, sda, av, dd, sdi, match, slew, smbus, sck, oe, sdo;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rdq;
	logic [7:0] ab, db, rx;
	logic errq;
	wire pready;
	wire slverr;
	int miscompares = 0;
	int comparisons = 0;
	int cyc = 0;
	sspr_regs_top i_sspr_regs_top (.I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(slverr), .I_SCL_IN(scl), .I_SDA_IN(sda),
		.I_SCK_IN(1'b0), .I_SDI(sdi), .O_SCK_OUT(sck), .O_SCK_OE(oe), .O_SDO(sdo),
		.O_SCL_OUT(), .O_SCL_OE(), .O_SDA_OUT(), .O_SDA_OE(), .O_SLEW_LIMIT(slew),
		.O_SMBUS_INPUTS(smbus), .I_BUS_ADDR_VALID(av), .I_BUS_ADDR_BYTE(ab),
		.I_BUS_ADDR_HIGH(1'b0), .I_BUS_DATA_DONE(dd), .I_BUS_DATA_BYTE(db),
		.I_BUS_NACK(1'b0), .I_I2C_TX_BUSY(1'b0), .O_ADDR_MATCH(match));
	sspr_spi_peer i_sspr_spi_peer (.i_sck(sck), .i_oe(oe), .i_sdo(sdo), .i_tx(8'hc3),
		.o_sdi(sdi), .o_rx(rx));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic give_verdict;
		if (miscompares == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			give_verdict;
		end
	end
	task automatic apb(input [15:0] a, input w, input [7:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge clk) pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rdq = prdata;
		errq = slverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input [15:0] a, input [7:0] e, input [7:0] m, input string nm);
		apb(a, 1'b0, 8'h00);
		`CHK(nm, e, rdq[7:0] & m)
	endtask
	task automatic addr(input [7:0] b, input e);
		av <= 1'b1;
		ab <= b;
		@(negedge clk) `CHK("match", e, match)
		@(posedge clk) av <= 1'b0;
		@(posedge clk);
	endtask
	initial begin
		{rst_n, psel, pen, pwr, av, dd, paddr, pwdata, ab, db} = '0;
		{scl, sda} = 2'b11;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(`SSPR_ADDR_ADD, 8'h00, 8'hff, "add_rst");
		rd(`SSPR_ADDR_MSK, 8'hff, 8'hff, "msk_rst");
		rd(`SSPR_ADDR_STAT, 8'h00, 8'hff, "stat_rst");
		apb(16'h1a44, 1'b1, 8'h11);
		`CHK("slverr", 1'b1, errq)
		apb(`SSPR_ADDR_STAT, 1'b1, 8'hff);
		`CHK("slverr_ok", 1'b0, errq)
		rd(`SSPR_ADDR_STAT, 8'hc0, 8'hff, "stat_ro");
		apb(`SSPR_ADDR_CTRL, 1'b1, 8'h16);
		`CHK("smbus", 1'b1, smbus)
		`CHK("slew_off", 1'b0, slew)
		apb(`SSPR_ADDR_STAT, 1'b1, 8'h00);
		`CHK("slew_on", 1'b1, slew)
		apb(`SSPR_ADDR_ADD, 1'b1, 8'ha4);
		addr(8'ha6, 1'b0);
		addr(8'ha5, 1'b1);
		rd(`SSPR_ADDR_STAT, 8'h04, 8'h24, "rw_da");
		apb(`SSPR_ADDR_MSK, 1'b1, 8'hfd);
		addr(8'ha6, 1'b1);
		dd <= 1'b1;
		db <= 8'h3c;
		@(posedge clk) dd <= 1'b0;
		@(posedge clk);
		rd(`SSPR_ADDR_STAT, 8'h21, 8'h21, "da_bf");
		rd(`SSPR_ADDR_BUF, 8'h3c, 8'hff, "buf_rx");
		rd(`SSPR_ADDR_STAT, 8'h00, 8'h01, "bf_clr");
		sda <= 1'b0;
		repeat (4) @(posedge clk);
		rd(`SSPR_ADDR_STAT, 8'h08, 8'h18, "start");
		sda <= 1'b1;
		repeat (4) @(posedge clk);
		rd(`SSPR_ADDR_STAT, 8'h10, 8'h18, "stop");
		apb(`SSPR_ADDR_CTRL, 1'b1, 8'h06);
		rd(`SSPR_ADDR_STAT, 8'h00, 8'h18, "dis");
		apb(`SSPR_ADDR_CTRL, 1'b1, 8'h17);
		apb(`SSPR_ADDR_ADD, 1'b1, 8'h34);
		apb(`SSPR_ADDR_MSK, 1'b1, 8'hfe);
		addr(8'h35, 1'b1);
		apb(`SSPR_ADDR_MSK, 1'b1, 8'hff);
		addr(8'h35, 1'b0);
		apb(`SSPR_ADDR_CTRL, 1'b1, 8'h1a);
		apb(`SSPR_ADDR_ADD, 1'b1, 8'h03);
		apb(`SSPR_ADDR_BUF, 1'b1, 8'h5a);
		repeat (200) @(posedge clk);
		`CHK("sdo", 8'h5a, rx)
		rd(`SSPR_ADDR_BUF, 8'hc3, 8'hff, "spi_rx");
		give_verdict;
	end
endmodule // sspr_regs_top_bench
`default_nettype wire

// *** bench/sspr_regs_top_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "sspr_regs.vh"
module sspr_chk (
	input wire I_CLK,
	input wire I_RST_N,
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire I_PWRITE,
	input wire [15:0] I_PADDR,
	input wire [31:0] I_PWDATA,
	input wire [31:0] O_PRDATA,
	input wire O_PREADY,
	input wire O_PSLVERR,
	input wire I_BUS_ADDR_VALID,
	input wire O_SCK_OUT,
	input wire O_SCK_OE,
	input wire O_SCL_OE,
	input wire O_SDA_OE,
	input wire O_ADDR_MATCH
);
	wire acc = I_PSEL && I_PENABLE;
	wire mapped = I_PADDR >= `SSPR_ADDR_BUF && I_PADDR <= `SSPR_ADDR_CTRL && I_PADDR[1:0] == 2'b00;
	reg [7:0] div_q;
	reg [9:0] half_q;
	reg sck_q;
	reg seen_q;
	// Cycles since the serial clock last toggled inside a frame
	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			div_q <= 8'h00;
			half_q <= 10'h000;
			sck_q <= 1'b0;
			seen_q <= 1'b0;
		end else begin
			if (acc && I_PWRITE && I_PADDR == `SSPR_ADDR_ADD)
				div_q <= I_PWDATA[7:0];
			half_q <= (O_SCK_OUT != sck_q) ? 10'h001 : half_q + 10'h001;
			sck_q <= O_SCK_OUT;
			seen_q <= O_SCK_OE && (seen_q || O_SCK_OUT != sck_q);
		end
	end
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	a_ready_high: assert property (O_PREADY) else $error("pready low");
	a_err_unmapped: assert property (acc && !mapped |-> O_PSLVERR) else $error("no slverr");
	a_err_mapped: assert property (acc && mapped |-> !O_PSLVERR) else $error("bad slverr");
	a_upper_zero: assert property (O_PRDATA[31:8] == 24'h00_0000) else $error("upper bits");
	a_match_cause: assert property (O_ADDR_MATCH |-> I_BUS_ADDR_VALID) else $error("match");
	a_half_period: assert property (O_SCK_OE && seen_q && O_SCK_OUT != sck_q
		|-> half_q == 2 * (div_q + 1)) else $error("sck half period");
	a_sck_still: assert property (!O_SCK_OE && $past(!O_SCK_OE) |-> $stable(O_SCK_OUT))
		else $error("sck moves idle");
	a_i2c_released: assert property (!O_SCL_OE && !O_SDA_OE) else $error("i2c driven");
endmodule // sspr_chk
bind sspr_regs_top sspr_chk i_sspr_chk (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL),
	.I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
	.O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
	.I_BUS_ADDR_VALID(I_BUS_ADDR_VALID), .O_SCK_OUT(O_SCK_OUT), .O_SCK_OE(O_SCK_OE),
	.O_SCL_OE(O_SCL_OE), .O_SDA_OE(O_SDA_OE), .O_ADDR_MATCH(O_ADDR_MATCH));
`default_nettype wire

// *** bench/sspr_spi_peer.sv ***
`timescale 1ns/1ns
`default_nettype none
module sspr_spi_peer (
	input wire logic i_sck,
	input wire logic i_oe,
	input wire logic i_sdo,
	input wire logic [7:0] i_tx,
	output logic o_sdi,
	output logic [7:0] o_rx
);
	int n_q = 0;
	initial o_sdi = 1'b0;
	always @(posedge i_sck) begin
		o_sdi <= i_tx[7 - n_q];
		n_q <= n_q + 1;
	end
	always @(negedge i_sck) o_rx <= {o_rx[6:0], i_sdo};
	// Released line shows the inverse, not a held value
	always @(negedge i_oe) begin
		o_sdi <= ~o_sdi;
		n_q <= 0;
	end
endmodule // sspr_spi_peer
`default_nettype wire

// *** include/sspr_regs.vh ***
`ifndef SSPR_REGS_VH
`define SSPR_REGS_VH
// Register indices as printed; byte address is four times the index
`define SSPR_IDX_BUF 16'h068c
`define SSPR_IDX_ADD 16'h068d
`define SSPR_IDX_MSK 16'h068e
`define SSPR_IDX_STAT 16'h068f
`define SSPR_IDX_CTRL 16'h0690
`define SSPR_ADDR_BUF 16'h1a30
`define SSPR_ADDR_ADD 16'h1a34
`define SSPR_ADDR_MSK 16'h1a38
`define SSPR_ADDR_STAT 16'h1a3c
`define SSPR_ADDR_CTRL 16'h1a40
// Status fields
`define SSPR_ST_SMP 7
`define SSPR_ST_CKE 6
`define SSPR_ST_DA 5
`define SSPR_ST_P 4
`define SSPR_ST_S 3
`define SSPR_ST_RW 2
`define SSPR_ST_UA 1
`define SSPR_ST_BF 0
// Control fields
`define SSPR_CT_EN 4
`define SSPR_RST_ADD 8'h00
`define SSPR_RST_MSK 8'hff
`define SSPR_RST_STAT 8'h00
`define SSPR_RST_CTRL 8'h00
`define SSPR_OSC_PER_SCK 4
// Modes
`define SSPR_M_SPI_CLIENT 4'h4
`define SSPR_M_SPI_CLIENT_NOSS 4'h5
`define SSPR_M_I2C_C7 4'h6
`define SSPR_M_I2C_C10 4'h7
`define SSPR_M_I2C_HOST 4'h8
`define SSPR_M_SPI_HOST 4'ha
`define SSPR_M_I2C_FW 4'hb
`define SSPR_M_I2C_C7SP 4'he
`define SSPR_M_I2C_C10SP 4'hf
`endif

// *** verilog/sspr_baud_gen.v ***
`timescale 1ns/1ns
`default_nettype none
`include "sspr_regs.vh"
// Half-period tick: reloads with the divider twice per serial clock
module sspr_baud_gen (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_run,
	input wire [7:0] i_div,
	output reg o_half_tick
);
	reg [9:0] cnt_q;
	// Half period = (n+1)*4/2 oscillator cycles
	wire [9:0] half = ({2'b00, i_div} + 10'h001) * 10'h002 - 10'h001;
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= 10'h000;
			o_half_tick <= 1'b0;
		end else if (!i_run) begin
			cnt_q <= half;
			o_half_tick <= 1'b0;
		end else if (cnt_q == 10'h000) begin
			cnt_q <= half;
			o_half_tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q - 10'h001;
			o_half_tick <= 1'b0;
		end
	end
endmodule // sspr_baud_gen
`default_nettype wire

// *** verilog/sspr_regs_top.v ***
// The APB slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "sspr_regs.vh"
// Function
// - Eight-bit buffer: written bytes sent in SPI modes only, received read
// - Host serial period is (n+1)*4 clocks
// - Ten-bit high address uses bits 2:1
// - Ten-bit low address uses all bits
// - Seven-bit address is bits 7:1
// - Mask bits 7:1 select compared bits; only bits 2:1 on the ten-bit high byte
// - Mask bit zero only in ten-bit
// - Sample phase: end or middle sampling
// - I2C slew limit follows sample phase
// - Edge select picks transmit clock edge
// - Data-or-address flag tracks last byte
// - Stop flag set on last Stop
// - Start flag set on last Start
// - Read-write bit: host transmit, client direction
// - Client direction held until Start/Stop/NACK
// - Update-address flag in ten-bit client
// - Buffer full: transmit busy or byte waiting
// - Start/Stop flags clear on disable
module sspr_regs_top (
	input wire I_CLK,
	input wire I_RST_N,
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire I_PWRITE,
	input wire [15:0] I_PADDR,
	input wire [31:0] I_PWDATA,
	output wire [31:0] O_PRDATA,
	output wire O_PREADY,
	output wire O_PSLVERR,
	input wire I_SCL_IN,
	input wire I_SDA_IN,
	input wire I_SCK_IN,
	input wire I_SDI,
	output reg O_SCK_OUT,
	output reg O_SCK_OE,
	output reg O_SDO,
	output wire O_SCL_OUT,
	output wire O_SCL_OE,
	output wire O_SDA_OUT,
	output wire O_SDA_OE,
	output wire O_SLEW_LIMIT,
	output wire O_SMBUS_INPUTS,
	input wire I_BUS_ADDR_VALID,
	input wire [7:0] I_BUS_ADDR_BYTE,
	input wire I_BUS_ADDR_HIGH,
	input wire I_BUS_DATA_DONE,
	input wire [7:0] I_BUS_DATA_BYTE,
	input wire I_BUS_NACK,
	input wire I_I2C_TX_BUSY,
	output wire O_ADDR_MATCH
);
	reg [7:0] buf_q;
	reg [7:0] add_q;
	reg [7:0] msk_q;
	reg [7:0] ctrl_q;
	reg smp_q, cke_q, da_q, p_q, s_q, rw_q, ua_q, bf_q;
	reg [31:0] rdata_q;
	reg err_q;
	// Pin synchronisers
	reg [3:0] sy1_q, sy2_q, last_q;
	wire scl_s = sy2_q[0];
	wire sda_s = sy2_q[1];
	wire sck_s = sy2_q[2];
	wire sdi_s = sy2_q[3];
	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			sy1_q <= 4'hb;
			sy2_q <= 4'hb;
			last_q <= 4'hb;
		end else begin
			sy1_q <= {I_SDI, I_SCK_IN, I_SDA_IN, I_SCL_IN};
			sy2_q <= sy1_q;
			last_q <= sy2_q;
		end
	end
	wire en = ctrl_q[`SSPR_CT_EN];
	wire [3:0] mode = ctrl_q[3:0];
	wire spi_host = mode == `SSPR_M_SPI_HOST;
	wire spi_cli = (mode == `SSPR_M_SPI_CLIENT) || (mode == `SSPR_M_SPI_CLIENT_NOSS);
	wire spi = spi_host || spi_cli;
	wire i2c = !spi;
	wire i2c_host = (mode == `SSPR_M_I2C_HOST) || (mode == `SSPR_M_I2C_FW);
	wire c10 = (mode == `SSPR_M_I2C_C10) || (mode == `SSPR_M_I2C_C10SP);
	wire c7 = (mode == `SSPR_M_I2C_C7) || (mode == `SSPR_M_I2C_C7SP);
	// APB: zero wait states
	wire acc = I_PSEL && I_PENABLE;
	wire hit = (I_PADDR == `SSPR_ADDR_BUF) || (I_PADDR == `SSPR_ADDR_ADD) ||
		(I_PADDR == `SSPR_ADDR_MSK) || (I_PADDR == `SSPR_ADDR_STAT) ||
		(I_PADDR == `SSPR_ADDR_CTRL);
	wire wr = acc && I_PWRITE;
	wire wr_buf = wr && (I_PADDR == `SSPR_ADDR_BUF);
	wire rd_buf = acc && !I_PWRITE && (I_PADDR == `SSPR_ADDR_BUF);
	assign O_PREADY = 1'b1;
	assign O_PRDATA = rdata_q;
	assign O_PSLVERR = acc && err_q;
	wire [7:0] stat = {smp_q, cke_q, da_q, p_q, s_q, rw_q, ua_q, bf_q};
	reg [31:0] rd_d;
	always @* begin
		rd_d = 32'h0000_0000;
		case (I_PADDR)
		`SSPR_ADDR_BUF: rd_d = {24'h00_0000, buf_q};
		`SSPR_ADDR_ADD: rd_d = {24'h00_0000, add_q};
		`SSPR_ADDR_MSK: rd_d = {24'h00_0000, msk_q};
		`SSPR_ADDR_STAT: rd_d = {24'h00_0000, stat};
		`SSPR_ADDR_CTRL: rd_d = {24'h00_0000, ctrl_q};
		default: rd_d = 32'h0000_0000;
		endcase
	end
	// SPI host shifter
	reg [7:0] sh_q;
	reg [3:0] hcnt_q;
	reg busy_q;
	wire half_tick;
	sspr_baud_gen u_baud (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_run(busy_q),
		.i_div(add_q),
		.o_half_tick(half_tick)
	);
	// Address match
	wire [7:0] own = c10 ? (I_BUS_ADDR_HIGH ? {5'h1e, add_q[2:1], 1'b0} : add_q)
		: {add_q[7:1], 1'b0};
	wire [7:0] cmp_msk = {msk_q[7:1], c10 ? msk_q[0] : 1'b0};
	// Ten-bit high byte: only bits 2:1 of the register matter
	wire [7:0] hi_msk = {5'h1f, msk_q[2:1], 1'b0};
	wire [7:0] use_msk = (c10 && I_BUS_ADDR_HIGH) ? hi_msk : cmp_msk;
	wire match = (((I_BUS_ADDR_BYTE ^ own) & use_msk) == 8'h00) && (c10 || c7);
	assign O_ADDR_MATCH = I_BUS_ADDR_VALID && match;
	assign O_SLEW_LIMIT = i2c && en && !smp_q;
	assign O_SMBUS_INPUTS = i2c && en && cke_q;
	assign O_SCL_OUT = 1'b0;
	assign O_SCL_OE = 1'b0;
	assign O_SDA_OUT = 1'b0;
	assign O_SDA_OE = 1'b0;
	wire start_ev = last_q[1] && !sy2_q[1] && scl_s;
	wire stop_ev = !last_q[1] && sda_s && scl_s;
	wire sck_rise = !last_q[2] && sck_s;
	wire sck_fall = last_q[2] && !sck_s;
	localparam [7:0] RST_STAT = `SSPR_RST_STAT;

	// Read data and error latched in setup so they stand through the access phase
	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
		end else if (I_PSEL && !I_PENABLE) begin
			err_q <= !hit;
			if (!I_PWRITE)
				rdata_q <= rd_d;
		end
	end

	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N)
			add_q <= `SSPR_RST_ADD;
		else if (wr && I_PADDR == `SSPR_ADDR_ADD)
			add_q <= I_PWDATA[7:0];
	end

	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N)
			msk_q <= `SSPR_RST_MSK;
		else if (wr && I_PADDR == `SSPR_ADDR_MSK)
			msk_q <= I_PWDATA[7:0];
	end

	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N)
			ctrl_q <= `SSPR_RST_CTRL;
		else if (wr && I_PADDR == `SSPR_ADDR_CTRL)
			ctrl_q <= I_PWDATA[7:0];
	end

	// Only the two control bits of the status register take software writes
	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			smp_q <= RST_STAT[7];
			cke_q <= RST_STAT[6];
		end else if (wr && I_PADDR == `SSPR_ADDR_STAT) begin
			smp_q <= I_PWDATA[`SSPR_ST_SMP];
			cke_q <= I_PWDATA[`SSPR_ST_CKE];
		end
	end

	// Host frame: even half is the leading edge, odd half the trailing edge
	wire lead_tick = busy_q && half_tick && !hcnt_q[0];
	wire trail_tick = busy_q && half_tick && hcnt_q[0];
	wire last_tick = trail_tick && (hcnt_q == 4'hf);
	// Middle of the output time is the edge opposite the launch edge
	wire samp_lead = cke_q ^ smp_q;
	wire host_start = wr_buf && spi_host && en && !busy_q;
	wire host_samp = samp_lead ? lead_tick : trail_tick;
	reg [7:0] host_rx_q;
	reg host_sdo_q;
	wire [7:0] host_rx_d = {host_rx_q[6:0], sdi_s};
	wire [7:0] host_byte = host_samp ? host_rx_d : host_rx_q;

	// Clock idles low between frames
	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			sh_q <= 8'h00;
			host_rx_q <= 8'h00;
			hcnt_q <= 4'h0;
			busy_q <= 1'b0;
			host_sdo_q <= 1'b0;
			O_SCK_OUT <= 1'b0;
			O_SCK_OE <= 1'b0;
		end else if (host_start) begin
			sh_q <= I_PWDATA[7:0];
			hcnt_q <= 4'h0;
			busy_q <= 1'b1;
			O_SCK_OE <= 1'b1;
			if (cke_q)
				host_sdo_q <= I_PWDATA[7];
		end else if (busy_q && half_tick) begin
			O_SCK_OUT <= ~O_SCK_OUT;
			hcnt_q <= hcnt_q + 4'h1;
			if (host_samp)
				host_rx_q <= host_rx_d;
			if (cke_q && trail_tick && !last_tick) begin
				host_sdo_q <= sh_q[6];
				sh_q <= {sh_q[6:0], 1'b0};
			end
			if (!cke_q && lead_tick) begin
				host_sdo_q <= sh_q[7];
				sh_q <= {sh_q[6:0], 1'b0};
			end
			if (last_tick) begin
				busy_q <= 1'b0;
				O_SCK_OE <= 1'b0;
				O_SCK_OUT <= 1'b0;
			end
		end
	end

	// SPI client: sample on the edge opposite to launch
	reg [7:0] cli_sh_q;
	reg [2:0] cli_cnt_q;
	reg cli_sdo_q;
	wire cli_on = en && spi_cli;
	wire cli_samp = cli_on && (cke_q ? sck_rise : sck_fall);
	wire cli_launch = cli_on && (cke_q ? sck_fall : sck_rise);
	wire [7:0] cli_rx_d = {cli_sh_q[6:0], sdi_s};
	wire cli_done = cli_samp && (cli_cnt_q == 3'h7);

	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			cli_sh_q <= 8'h00;
			cli_cnt_q <= 3'h0;
			cli_sdo_q <= 1'b0;
		end else if (!cli_on) begin
			cli_cnt_q <= 3'h0;
		end else begin
			if (wr_buf)
				cli_sh_q <= I_PWDATA[7:0];
			else if (cli_samp)
				cli_sh_q <= cli_rx_d;
			if (cli_samp)
				cli_cnt_q <= cli_cnt_q + 3'h1;
			if (cli_launch)
				cli_sdo_q <= cli_sh_q[7];
		end
	end

	// Data out follows the active engine one clock later
	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N)
			O_SDO <= 1'b0;
		else
			O_SDO <= spi_cli ? cli_sdo_q : host_sdo_q;
	end

	// Buffer and status flags; later assignments let a set beat a clear
	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			buf_q <= 8'h00;
			{da_q, p_q, s_q, rw_q, ua_q, bf_q} <= RST_STAT[5:0];
		end else begin
			if (rd_buf && !busy_q && !I_I2C_TX_BUSY)
				bf_q <= 1'b0;
			if (wr_buf)
				buf_q <= I_PWDATA[7:0];
			if (last_tick) begin
				buf_q <= host_byte;
				bf_q <= 1'b1;
			end
			if (cli_done) begin
				buf_q <= cli_rx_d;
				bf_q <= 1'b1;
			end
			if (en && i2c) begin
				if (I_I2C_TX_BUSY)
					bf_q <= 1'b1;
				if (i2c_host)
					rw_q <= I_I2C_TX_BUSY;
				if (start_ev) begin
					s_q <= 1'b1;
					p_q <= 1'b0;
				end
				if (stop_ev) begin
					p_q <= 1'b1;
					s_q <= 1'b0;
				end
				if (!i2c_host && (start_ev || stop_ev || I_BUS_NACK))
					rw_q <= 1'b0;
				if (c10 && wr && I_PADDR == `SSPR_ADDR_ADD)
					ua_q <= 1'b0;
				if (I_BUS_ADDR_VALID && match) begin
					da_q <= 1'b0;
					if (!c10 || I_BUS_ADDR_HIGH)
						rw_q <= I_BUS_ADDR_BYTE[0];
					if (c10)
						ua_q <= 1'b1;
					buf_q <= I_BUS_ADDR_BYTE;
					bf_q <= 1'b1;
				end
				if (I_BUS_DATA_DONE && !i2c_host) begin
					da_q <= 1'b1;
					buf_q <= I_BUS_DATA_BYTE;
					bf_q <= 1'b1;
				end
			end
			if (!en) begin
				s_q <= 1'b0;
				p_q <= 1'b0;
			end
		end
	end

endmodule // sspr_regs_top
`default_nettype wire
